/* tb/modem_model.sv */
// modem partner model: drives the four handshake lines and the serial line
`timescale 1ns/100ps
`default_nettype none

module modem_model (
  input  wire logic                         pclk,
  input  wire uart_modem_pkg::modem_lines_t want,
  input  wire logic                         noise,
  output logic                              cts_n,
  output logic                              dsr_n,
  output logic                              dcd_n,
  output logic                              ri_n,
  output logic                              serial_in
);
  // lines idle inactive high and the serial line idles at mark
  initial begin
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
    serial_in = 1'b1;
  end

  // active-low pins follow the wanted levels just after each rising edge
  always @(posedge pclk) begin
    {dcd_n, ri_n, dsr_n, cts_n} <= ~want;
    serial_in <= noise ? ~serial_in : 1'b1; // toggles every cycle so a leak is seen
  end
endmodule : modem_model

`default_nettype wire

/* tb/uart_modem_loopback_baud_tb.sv */
// self-checking bench of the modem control, status, loopback and baud block
`timescale 1ns/100ps
`default_nettype none

module uart_modem_loopback_baud_tb;
  logic        pclk, presetn, psel, penable, pwrite, tx_bit, noise, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, serial_in, serial_out, cts_n, dsr_n, dcd_n, ri_n;
  logic        dtr_n, rts_n, ua_n, ub_n, rx_bit, modem_irq, sleep_inhibit;
  logic        auto_rts_en, auto_cts_en, buf64, tick;
  uart_modem_pkg::modem_lines_t want;
  int          miscompares, check_count, n, ticks;
  // rows: control value [15:8], pins dtr,rts,a,b [7:4], auto rts,cts [1:0]
  logic [15:0] rows [5] = '{16'h00F0, 16'h0F00, 16'h20F1, 16'h22B3, 16'h0550};
  int          divs [2] = '{3, 1}; // pclk/(16*rate) for two rates

  uart_modem_loopback_baud DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .ri_n(ri_n), .serial_in(serial_in), .serial_out(serial_out),
    .dtr_n(dtr_n), .rts_n(rts_n), .user_output_a_n(ua_n), .user_output_b_n(ub_n),
    .transmit_shift_out(tx_bit), .receive_shift_in(rx_bit), .modem_irq(modem_irq),
    .sleep_inhibit(sleep_inhibit), .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en),
    .flow_buffer_64(buf64), .baud16_tick(tick));

  modem_model partner (.pclk(pclk), .want(want), .noise(noise), .cts_n(cts_n),
    .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .serial_in(serial_in));

  // clock and tick counter
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (tick === 1'b1) ticks++;

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) miscompares++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc

  // cycles until the next tick is seen
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (tick !== 1'b1 && g < 5000);
  endtask : gap

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    ticks = 0;
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, tx_bit, noise} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 4'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk({dtr_n, rts_n, ua_n, ub_n, serial_out, rx_bit}, 6'h3F);
    rd_chk(uart_modem_pkg::OFS_MODEM_CTL, 32'h0);
    apb(1'b0, uart_modem_pkg::OFS_MODEM_STA, 32'h0);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'h0);
    foreach (rows[i]) begin
      wr(uart_modem_pkg::OFS_MODEM_CTL, {24'h0, rows[i][15:8]});
      cyc(1);
      chk({dtr_n, rts_n, ua_n, ub_n}, rows[i][7:4]);
      chk({auto_rts_en, auto_cts_en}, rows[i][1:0]);
      rd_chk(uart_modem_pkg::OFS_MODEM_CTL, {24'h0, rows[i][15:8]});
    end
    // status change bits, interrupt and sleep hold-off
    wr(uart_modem_pkg::OFS_MODEM_CTL, 32'h0);
    wr(uart_modem_pkg::OFS_IEN_DIVHI, 32'h08);
    want.cts <= 1'b1;
    cyc(6);
    chk({modem_irq, sleep_inhibit}, 2'b11);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'h11);
    cyc(2);
    chk({modem_irq, sleep_inhibit}, 2'b00);
    wr(uart_modem_pkg::OFS_MODEM_CTL, 32'h20);
    want.cts <= 1'b0;
    cyc(6);
    chk(modem_irq, 1'b0);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'h01);
    wr(uart_modem_pkg::OFS_MODEM_CTL, 32'h0);
    want.ri <= 1'b1;
    cyc(5);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'h40);
    want.ri <= 1'b0;
    cyc(6);
    chk(modem_irq, 1'b1);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'h04);
    want <= 4'hA;
    cyc(6);
    chk(modem_irq, 1'b1);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'hAA);
    wr(uart_modem_pkg::OFS_IEN_DIVHI, 32'h0);
    want <= 4'h0;
    cyc(6);
    chk(modem_irq, 1'b0);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'h0A);
    // loopback with a noisy serial line and active modem lines
    wr(uart_modem_pkg::OFS_IEN_DIVHI, 32'h08);
    noise <= 1'b1;
    wr(uart_modem_pkg::OFS_MODEM_CTL, 32'h1B);
    cyc(3);
    chk({dtr_n, rts_n, ua_n, ub_n, serial_out, rx_bit}, 6'h3E);
    tx_bit <= 1'b1;
    cyc(3);
    chk({rx_bit, modem_irq}, 2'b11);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'hBB);
    want <= 4'hF;
    cyc(5);
    rd_chk(uart_modem_pkg::OFS_MODEM_STA, 32'hB0);
    noise <= 1'b0;
    wr(uart_modem_pkg::OFS_MODEM_CTL, 32'h0);
    tx_bit <= 1'b0;
    cyc(3);
    chk({serial_out, rx_bit}, 2'b01);
    // buffer size select and an unmapped place
    wr(uart_modem_pkg::OFS_FIFO_CTRL, 32'h20);
    cyc(1);
    chk(buf64, 1'b1);
    wr(uart_modem_pkg::OFS_FIFO_CTRL, 32'h0);
    cyc(1);
    chk(buf64, 1'b0);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    // baud divisor: long count cut short by a latch write, then periods
    wr(uart_modem_pkg::OFS_LINE_CTRL, 32'h80);
    wr(uart_modem_pkg::OFS_IEN_DIVHI, 32'h10);
    wr(uart_modem_pkg::OFS_DIVLO, 32'h03);
    n = ticks;
    cyc(40);
    chk(ticks - n, 0);
    foreach (divs[i]) begin
      wr(uart_modem_pkg::OFS_DIVLO, divs[i]);
      wr(uart_modem_pkg::OFS_IEN_DIVHI, 32'h0);
      gap(n);
      chk(n <= 8, 1);
      gap(n);
      chk(n, divs[i]);
    end
    rd_chk(uart_modem_pkg::OFS_DIVLO, 32'h01);
    rd_chk(uart_modem_pkg::OFS_IEN_DIVHI, 32'h0);
    wr(uart_modem_pkg::OFS_LINE_CTRL, 32'h0);
    rd_chk(uart_modem_pkg::OFS_DIVLO, 32'h0);
    report_and_stop();
  end
endmodule : uart_modem_loopback_baud_tb

`default_nettype wire

/* verilog/baud_divider.sv */
// baud divider: programmable divide of the reference clock to the 16x tick
`timescale 1ns/100ps
`default_nettype none

module baud_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] divisor,
  input  wire logic        reload,
  output logic             tick
);

  logic [15:0] count;

  // count down from the divisor; a zero divisor stops the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (reload) begin
      count <= divisor;
      tick  <= 1'b0;
    end else if (divisor == 16'h0000) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (count <= 16'h0001) begin
      count <= divisor;
      tick  <= 1'b1;
    end else begin
      count <= count - 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule : baud_divider

`default_nettype wire

/* verilog/uart_modem_loopback_baud.sv */
// top: modem control, loopback, flow decode, modem status and baud divisor
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - loopback: output high, input ignored, shift looped
// - loopback: modem pins cut, outputs high, internally routed
// - loopback modem interrupts come from control bits
// - control bit 5 enables automatic flow
// - flow enable with rts selects auto rts/cts
// - fifo bit 5 picks 16 or 64 byte
// - change bits set on change, cleared by read
// - cts change interrupts only with flow off
// - dsr and dcd changes raise interrupt
// - ring bit sets on ri low to high
// - any change bit blocks sleep
// - status bits 7..4 are inverted input levels
// - loopback status bits mirror control bits 1,0,2,3
// - divisor 1..65535 gives the 16x clock
// - divisor is two 8-bit latches
// - latch write reloads the baud counter
// - control bits 0..3 set drive pins low
module uart_modem_loopback_baud (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        dcd_n,
  input  wire logic        ri_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             user_output_a_n,
  output logic             user_output_b_n,
  input  wire logic        transmit_shift_out,
  output logic             receive_shift_in,
  output logic             modem_irq,
  output logic             sleep_inhibit,
  output logic             auto_rts_en,
  output logic             auto_cts_en,
  output logic             flow_buffer_64,
  output logic             baud16_tick
);

  uart_modem_pkg::bus_state_t   bus_state;
  uart_modem_pkg::modem_lines_t pin_meta;
  uart_modem_pkg::modem_lines_t pin_sync;
  uart_modem_pkg::modem_lines_t lines;
  uart_modem_pkg::modem_lines_t next_lines;
  logic                               sin_meta;
  logic                               sin_sync;
  logic [uart_modem_pkg::MC_W-1:0]    modem_control;
  logic [7:0]                         line_control;
  logic [3:0]                         int_enable;
  logic                               fifo_ext;
  logic [15:0]                        divisor;
  logic                               div_reload;
  logic [3:0]                         changes;
  logic [3:0]                         next_events;
  logic [3:0]                         read_capture;
  logic                               loop;
  logic                               afe;
  logic                               divisor_access_bit;
  logic                               setup;
  logic                               fire;
  logic                               wr;
  logic                               rd_status;
  logic                               mapped;

  assign loop = modem_control[uart_modem_pkg::MC_LOOP];
  assign afe  = modem_control[uart_modem_pkg::MC_AFE];
  assign divisor_access_bit = line_control[uart_modem_pkg::LC_DIV_ACCESS];

  // bus phase decode
  assign setup     = psel && !penable;
  assign fire      = psel && penable && pready;
  assign wr        = fire && pwrite && pstrb[0];
  assign rd_status = fire && !pwrite && (paddr == uart_modem_pkg::OFS_MODEM_STA);

  // address map check
  always_comb begin
    case (paddr)
      uart_modem_pkg::OFS_DIVLO,
      uart_modem_pkg::OFS_IEN_DIVHI,
      uart_modem_pkg::OFS_FIFO_CTRL,
      uart_modem_pkg::OFS_LINE_CTRL,
      uart_modem_pkg::OFS_MODEM_CTL,
      uart_modem_pkg::OFS_MODEM_STA: mapped = 1'b1;
      default:                       mapped = 1'b0;
    endcase
  end

  // two-flop synchronisers for the modem and serial input pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '1;
      pin_sync <= '1;
      sin_meta <= 1'b1;
      sin_sync <= 1'b1;
    end else begin
      pin_meta <= '{dcd: dcd_n, ri: ri_n, dsr: dsr_n, cts: cts_n};
      pin_sync <= pin_meta;
      sin_meta <= serial_in;
      sin_sync <= sin_meta;
    end
  end

  // active line levels: inverted pins, or control bits while looped
  always_comb begin
    if (loop) begin
      next_lines.cts = modem_control[uart_modem_pkg::MC_RTS];
      next_lines.dsr = modem_control[uart_modem_pkg::MC_DTR];
      next_lines.ri  = modem_control[uart_modem_pkg::MC_UA];
      next_lines.dcd = modem_control[uart_modem_pkg::MC_UB];
    end else begin
      next_lines = ~pin_sync;
    end
  end

  // change events: any edge for cts, dsr, dcd; falling active ri only
  always_comb begin
    next_events[0] = next_lines.cts != lines.cts;
    next_events[1] = next_lines.dsr != lines.dsr;
    next_events[2] = lines.ri && !next_lines.ri;
    next_events[3] = next_lines.dcd != lines.dcd;
  end

  // status line levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= '0;
    end else begin
      lines <= next_lines;
    end
  end

  // sticky change bits; a read clears only what it returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      changes <= 4'h0;
    end else if (rd_status) begin
      changes <= (changes & ~read_capture) | next_events;
    end else begin
      changes <= changes | next_events;
    end
  end

  // bus handshake: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= uart_modem_pkg::BUS_IDLE;
      pready    <= 1'b0;
    end else begin
      case (bus_state)
        uart_modem_pkg::BUS_IDLE: begin
          if (setup) begin
            bus_state <= uart_modem_pkg::BUS_ANSWER;
            pready    <= 1'b1;
          end
        end
        uart_modem_pkg::BUS_ANSWER: begin
          bus_state <= uart_modem_pkg::BUS_IDLE;
          pready    <= 1'b0;
        end
        default: begin
          bus_state <= uart_modem_pkg::BUS_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
      read_capture <= 4'h0;
    end else if (setup) begin
      pslverr      <= !mapped;
      read_capture <= 4'h0;
      prdata       <= 32'h0000_0000;
      case (paddr)
        uart_modem_pkg::OFS_DIVLO:
          prdata[7:0] <= divisor_access_bit ? divisor[7:0] : 8'h00;
        uart_modem_pkg::OFS_IEN_DIVHI:
          prdata[7:0] <= divisor_access_bit ? divisor[15:8] : {4'h0, int_enable};
        uart_modem_pkg::OFS_FIFO_CTRL:
          prdata[uart_modem_pkg::FC_EXT_BUF] <= fifo_ext;
        uart_modem_pkg::OFS_LINE_CTRL:
          prdata[7:0] <= line_control;
        uart_modem_pkg::OFS_MODEM_CTL:
          prdata[uart_modem_pkg::MC_W-1:0] <= modem_control;
        uart_modem_pkg::OFS_MODEM_STA: begin
          prdata[7:0]  <= {lines, changes};
          read_capture <= pwrite ? 4'h0 : changes;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control <= uart_modem_pkg::MC_RESET;
      line_control  <= uart_modem_pkg::LC_RESET;
      int_enable    <= uart_modem_pkg::IE_RESET;
      fifo_ext      <= 1'b0;
    end else if (wr) begin
      case (paddr)
        uart_modem_pkg::OFS_MODEM_CTL:
          modem_control <= pwdata[uart_modem_pkg::MC_W-1:0];
        uart_modem_pkg::OFS_LINE_CTRL:
          line_control <= pwdata[7:0];
        uart_modem_pkg::OFS_IEN_DIVHI:
          if (!divisor_access_bit) int_enable <= pwdata[3:0];
        uart_modem_pkg::OFS_FIFO_CTRL:
          fifo_ext <= pwdata[uart_modem_pkg::FC_EXT_BUF];
        default: fifo_ext <= fifo_ext;
      endcase
    end
  end

  // divisor latches, reached only with the access bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor    <= uart_modem_pkg::DIV_RESET;
      div_reload <= 1'b0;
    end else begin
      div_reload <= 1'b0;
      if (wr && divisor_access_bit && paddr == uart_modem_pkg::OFS_DIVLO) begin
        divisor[7:0] <= pwdata[7:0];
        div_reload   <= 1'b1;
      end
      if (wr && divisor_access_bit && paddr == uart_modem_pkg::OFS_IEN_DIVHI) begin
        divisor[15:8] <= pwdata[7:0];
        div_reload    <= 1'b1;
      end
    end
  end

  // modem output pins, forced high while looped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_n           <= 1'b1;
      rts_n           <= 1'b1;
      user_output_a_n <= 1'b1;
      user_output_b_n <= 1'b1;
    end else begin
      dtr_n           <= loop || !modem_control[uart_modem_pkg::MC_DTR];
      rts_n           <= loop || !modem_control[uart_modem_pkg::MC_RTS];
      user_output_a_n <= loop || !modem_control[uart_modem_pkg::MC_UA];
      user_output_b_n <= loop || !modem_control[uart_modem_pkg::MC_UB];
    end
  end

  // serial path with loopback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out       <= 1'b1;
      receive_shift_in <= 1'b1;
    end else begin
      serial_out       <= loop || transmit_shift_out;
      receive_shift_in <= loop ? transmit_shift_out : sin_sync;
    end
  end

  // modem interrupt, sleep guard and flow decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_irq      <= 1'b0;
      sleep_inhibit  <= 1'b0;
      auto_rts_en    <= 1'b0;
      auto_cts_en    <= 1'b0;
      flow_buffer_64 <= 1'b0;
    end else begin
      modem_irq      <= int_enable[uart_modem_pkg::IE_MODEM] &&
                        ((changes[0] && !afe) || (|changes[3:1]));
      sleep_inhibit  <= |changes;
      auto_rts_en    <= afe && modem_control[uart_modem_pkg::MC_RTS];
      auto_cts_en    <= afe;
      flow_buffer_64 <= fifo_ext;
    end
  end

  // 16x tick generator
  baud_divider u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (divisor),
    .reload  (div_reload),
    .tick    (baud16_tick)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_loop_serial_out_high: assert property (loop |=> serial_out)
    else $error("serial out not high in loopback");

  a_loop_rx_path: assert property (loop && $past(loop) |-> ##1
      receive_shift_in == $past(transmit_shift_out))
    else $error("loopback receive path broken");

  a_loop_pins_high: assert property (loop |=> dtr_n && rts_n && user_output_a_n
      && user_output_b_n)
    else $error("modem outputs not high in loopback");

  a_pin_drive_low: assert property (!loop && modem_control[uart_modem_pkg::MC_RTS]
      |=> !rts_n)
    else $error("rts pin not driven low");

  a_loop_status_map: assert property (loop |=>
      lines.cts == $past(modem_control[uart_modem_pkg::MC_RTS]) &&
      lines.dsr == $past(modem_control[uart_modem_pkg::MC_DTR]) &&
      lines.ri  == $past(modem_control[uart_modem_pkg::MC_UA]) &&
      lines.dcd == $past(modem_control[uart_modem_pkg::MC_UB]))
    else $error("loopback status mirror wrong");

  a_flow_decode: assert property (##1 auto_cts_en == $past(afe) &&
      auto_rts_en == ($past(afe) && $past(modem_control[uart_modem_pkg::MC_RTS])))
    else $error("flow decode wrong");

  a_cts_irq_gate: assert property (changes == 4'h1 && afe |=> !modem_irq)
    else $error("cts change interrupted with flow on");

  a_change_kept: assert property (next_events[3] |=> changes[3] ##1 sleep_inhibit)
    else $error("dcd change lost");

  a_read_clears: assert property (rd_status && next_events == 4'h0 |=>
      (changes & $past(read_capture)) == 4'h0)
    else $error("status read did not clear");

  a_ring_edge: assert property (!lines.ri && !changes[2] && !rd_status |=>
      !changes[2])
    else $error("ring bit set without trailing edge");

  a_div_reload: assert property (wr && divisor_access_bit && paddr == uart_modem_pkg::OFS_DIVLO
      |=> ##1 u_baud.count == divisor && !baud16_tick)
    else $error("baud counter not reloaded");

endmodule : uart_modem_loopback_baud

`default_nettype wire

/* verilog/uart_modem_pkg.sv */
// package: register map, field positions and carriers of the modem and baud block
package uart_modem_pkg;

  // register byte addresses, one aligned word each
  localparam logic [11:0] OFS_DIVLO     = 12'h000; // divisor low byte while access bit set
  localparam logic [11:0] OFS_IEN_DIVHI = 12'h004; // interrupt enable, or divisor high byte
  localparam logic [11:0] OFS_FIFO_CTRL = 12'h008;
  localparam logic [11:0] OFS_LINE_CTRL = 12'h00C;
  localparam logic [11:0] OFS_MODEM_CTL = 12'h010;
  localparam logic [11:0] OFS_MODEM_STA = 12'h018;

  // modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_UA   = 2;
  localparam int MC_UB   = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_AFE  = 5;
  localparam int MC_W    = 6;

  // other control fields
  localparam int LC_DIV_ACCESS = 7;
  localparam int FC_EXT_BUF    = 5;
  localparam int IE_MODEM      = 3;

  // reset values
  localparam logic [MC_W-1:0] MC_RESET  = 6'h00;
  localparam logic [7:0]      LC_RESET  = 8'h00;
  localparam logic [3:0]      IE_RESET  = 4'h0;
  localparam logic [15:0]     DIV_RESET = 16'h0000;

  // modem input lines in the order of status bits 7..4 and change bits 3..0
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_lines_t;

  // bus slave phases
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage : uart_modem_pkg
